// >>> shared/fse_params.svh
// Constants of the file-system command engine: offsets, layout, reset values
`ifndef FSE_PARAMS_SVH
`define FSE_PARAMS_SVH
// Register byte offsets on the Avalon-MM slave
`define FSE_REG_CTRL 5'h00
`define FSE_REG_STATUS 5'h04
`define FSE_REG_FCOUNT 5'h08
`define FSE_REG_FCAP 5'h0C
`define FSE_REG_FILES_PER_DIRECTORY 5'h10
`define FSE_REG_ERRCAUSE 5'h14
// Control register: bit 0 lets new commands in
`define FSE_CTRL_ACCEPT_BIT 0
`define FSE_CTRL_RST 32'h0000_0001
// Disk layout in sectors
`define FSE_META_LBA 48'h0000_0000_0800
`define FSE_DIR_LBA 48'h0000_0000_0801
`define FSE_DATA_LBA 48'h0000_0010_0000
`define FSE_FMT_SECTORS 48'h0000_0000_0201
`define FSE_SECT_WORDS_LOG2 7
`define FSE_FILE_SHIFT 6'h10
// Supported drive range in sectors: 8 GiB up to below 64 PiB
`define FSE_LBA_MIN 48'h0000_0100_0000
`define FSE_LBA_MAX 48'h8000_0000_0000
// Error cause field and receive FIFO room bit
`define FSE_ERR_CAP_BIT 24
`define FSE_RX_ROOM_LSB 3
`endif

// >>> shared/fse_pkg.sv
// Types of the file-system command engine
package fse_pkg;
  typedef enum logic [1:0] {
    FSE_ST_IDLE = 2'b00,
    FSE_ST_LOAD = 2'b01,
    FSE_ST_REQ = 2'b10,
    FSE_ST_RUN = 2'b11
  } fse_state_t;
  typedef enum logic [2:0] {
    FSE_PH_IDENT = 3'b000,
    FSE_PH_MREAD = 3'b001,
    FSE_PH_FMT = 3'b010,
    FSE_PH_DATA = 3'b011,
    FSE_PH_META = 3'b100,
    FSE_PH_CAT = 3'b101
  } fse_phase_t;
  typedef enum logic [1:0] {
    FSE_CMD_FORMAT = 2'b00,
    FSE_CMD_WRITE = 2'b10,
    FSE_CMD_READ = 2'b11
  } fse_cmd_t;
  typedef enum logic [1:0] {
    FSE_HC_IDENT = 2'b00,
    FSE_HC_READ = 2'b10,
    FSE_HC_WRITE = 2'b11
  } fse_hc_cmd_t;
endpackage : fse_pkg

// >>> core/fse_counter.sv
// Loadable up or down counter used for word tracking
`timescale 1ns/100ps
module fse_counter #(
  parameter int unsigned W = 8,
  parameter bit UP = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic step_i,
  // Result
  output logic [W-1:0] count_o,
  output logic zero_o
);
  import fse_pkg::*;
  // Load has priority over a step
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      count_o <= '0;
    else if (load_i)
      count_o <= load_val_i;
    else if (step_i)
      count_o <= UP ? count_o + W'(1) : count_o - W'(1);
  end
  assign zero_o = (count_o == '0);
endmodule : fse_counter

// >>> core/fse_avmm_regs.sv
// Avalon-MM slave holding the control register and status views
`timescale 1ns/100ps
`include "fse_params.svh"
module fse_avmm_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Engine state
  input wire logic [31:0] status_i,
  input wire logic [26:0] fcount_i,
  input wire logic [26:0] fcap_i,
  input wire logic [19:0] files_per_directory_i,
  input wire logic [31:0] errcause_i,
  output logic accept_en_o
);
  import fse_pkg::*;
  logic take;
  logic [31:0] rd_mux;
  // Every access waits exactly one cycle, then completes
  assign take = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
  end
  // Control write, only lane 0 carries a field
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      accept_en_o <= 1'(`FSE_CTRL_RST);
    else if (take && avs_write_i && avs_address_i == `FSE_REG_CTRL && avs_byteenable_i[0])
      accept_en_o <= avs_writedata_i[`FSE_CTRL_ACCEPT_BIT];
  end
  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_i)
      `FSE_REG_CTRL: rd_mux = {31'h0000_0000, accept_en_o};
      `FSE_REG_STATUS: rd_mux = status_i;
      `FSE_REG_FCOUNT: rd_mux = {5'h00, fcount_i};
      `FSE_REG_FCAP: rd_mux = {5'h00, fcap_i};
      `FSE_REG_FILES_PER_DIRECTORY: rd_mux = {12'h000, files_per_directory_i};
      `FSE_REG_ERRCAUSE: rd_mux = errcause_i;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Read data registered at the edge that drops waitrequest
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (~((avs_read_i | avs_write_i) & avs_waitrequest_o) == 1'b0)
      avs_readdata_o <= rd_mux;
  end
endmodule : fse_avmm_regs

// >>> core/fse_engine.sv
// File-system command engine between user logic and a storage host controller
// Operation
// - After reset, identify the drive and derive capacity figures from the answer.
// - Busy stays high during initialization, falls once the metadata read after identification is complete.
// - Files-per-directory valid after init; other figures only after own format; code also sets capacity, size and count from metadata at init.
// - Accepting a request raises busy and samples the parameters.
// - Format writes structures and 512 dated directories DIR000 to DIR1FF.
// - Format end updates capacity, sets file size, clears file count.
// - Write end raises count to start plus count when larger; files get date/time.
// - Files are named by seven zero-padded hex digits plus .BIN.
// - Transmit FIFO read only when not empty; data arrives next clock.
// - Exactly count times size/4 words move, then FIFO enable drops.
// - Stored file count is untouched by reads.
// - Receive FIFO written per controller word; pause raised the clock after fill bits 15:3 are all ones.
// - Receive writes stop within seven clocks of fill bits all ones.
// - Error flag on any error here or in host; cleared by reset only.
// - Files fill directories in consecutive groups of per-directory capacity.
// - Lower start overwrites; count never shrinks except by format.
// - Error cause mirrors host cause bits 15:0; bit 24 flags capacity.
`timescale 1ns/100ps
`include "fse_params.svh"
module fse_engine #(
  parameter int unsigned DIR_CAP = 512
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // User command interface
  input wire logic cmd_request_i,
  input wire logic [1:0] cmd_code_i,
  input wire logic [2:0] file_size_sel_i,
  input wire logic [26:0] start_file_number_i,
  input wire logic [26:0] file_count_i,
  input wire logic [31:0] creation_date_i,
  input wire logic [31:0] creation_time_i,
  output logic cmd_in_progress_o,
  output logic [26:0] max_file_capacity_o,
  output logic [19:0] files_per_directory_o,
  output logic [2:0] stored_file_size_o,
  output logic [26:0] stored_file_count_o,
  output logic error_flag_o,
  output logic [31:0] error_cause_o,
  // Transmit FIFO
  input wire logic tx_fifo_empty_i,
  output logic tx_fifo_read_en_o,
  input wire logic [31:0] tx_fifo_read_word_i,
  // Receive FIFO
  input wire logic [15:0] rx_fifo_fill_count_i,
  output logic rx_fifo_write_en_o,
  output logic [31:0] rx_fifo_write_word_o,
  // Host controller command side
  output logic [1:0] hc_cmd_o,
  output logic [47:0] hc_addr_o,
  output logic [47:0] hc_len_o,
  output logic hc_req_o,
  input wire logic hc_busy_i,
  input wire logic [47:0] hc_lba_size_i,
  input wire logic hc_error_i,
  input wire logic [31:0] hc_error_type_i,
  // Host controller data side
  output logic [31:0] hc_tx_word_o,
  output logic hc_tx_valid_o,
  input wire logic hc_tx_ready_i,
  input wire logic [31:0] hc_rx_word_i,
  input wire logic hc_rx_valid_i,
  output logic hc_rx_pause_o,
  // Avalon-MM register slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  import fse_pkg::*;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  fse_state_t state_r;
  fse_phase_t phase_r;
  fse_phase_t phase_nxt;
  fse_hc_cmd_t su_cmd;
  logic [1:0] cmd_r;
  logic [2:0] sel_r, meta_size_r, cap_size;
  logic [26:0] start_r, n_r, meta_count_r, count_nxt, cap_sat;
  logic [27:0] end_sum;
  logic [31:0] date_r, time_r, gen_word;
  logic [47:0] lba_r, su_addr, su_len, cap_full;
  logic [63:0] start_sec, len_sec;
  logic [5:0] sh, cap_sh;
  logic [8:0] dir_idx, dir_k;
  logic [55:0] rem_cnt;
  logic [16:0] idx_cnt;
  logic rem_zero, accept_en, accept, run, done, to_idle;
  logic src_fifo, src_gen, src_rx, rd_go, gen_go, rx_go, step;
  logic rd_pend_r, cap_err_r;

  // Hex digit to ASCII character
  function automatic logic [7:0] hex_ch(input logic [3:0] d);
    hex_ch = (d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
  endfunction : hex_ch

  // ********************************************************************
  // Command acceptance and sequencing
  // ********************************************************************
  // ignore while busy
  assign accept = (state_r == FSE_ST_IDLE) && cmd_request_i && accept_en && !error_flag_o
    && (cmd_code_i != 2'b01);
  assign run = (state_r == FSE_ST_RUN);
  assign done = run && rem_zero && !hc_tx_valid_o && !rd_pend_r && !tx_fifo_read_en_o
    && !hc_busy_i;

  // Phase that follows the finished one
  always_comb
  begin
    phase_nxt = phase_r;
    to_idle = 1'b1;
    unique case (phase_r)
      FSE_PH_IDENT:
      begin
        phase_nxt = FSE_PH_MREAD;
        to_idle = 1'b0;
      end
      FSE_PH_DATA:
      begin
        phase_nxt = FSE_PH_META;
        to_idle = (cmd_r == FSE_CMD_READ);
      end
      FSE_PH_META:
      begin
        phase_nxt = FSE_PH_CAT;
        to_idle = 1'b0;
      end
      default: to_idle = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= FSE_ST_LOAD;
      phase_r <= FSE_PH_IDENT;
    end
    else
    begin
      unique case (state_r)
        FSE_ST_IDLE:
          if (accept)
          begin
            state_r <= FSE_ST_LOAD;
            phase_r <= (cmd_code_i == FSE_CMD_FORMAT) ? FSE_PH_FMT : FSE_PH_DATA;
          end
        FSE_ST_LOAD: state_r <= FSE_ST_REQ;
        FSE_ST_REQ:
          if (hc_busy_i)
            state_r <= FSE_ST_RUN;
        FSE_ST_RUN:
          if (done)
          begin
            state_r <= to_idle ? FSE_ST_IDLE : FSE_ST_LOAD;
            phase_r <= phase_nxt;
          end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cmd_r <= 2'h0;
      sel_r <= 3'h0;
      start_r <= 27'h000_0000;
      n_r <= 27'h000_0000;
      date_r <= 32'h0000_0000;
      time_r <= 32'h0000_0000;
    end
    else if (accept)
    begin
      cmd_r <= cmd_code_i;
      sel_r <= file_size_sel_i;
      start_r <= start_file_number_i;
      n_r <= file_count_i;
      date_r <= creation_date_i;
      time_r <= creation_time_i;
    end
  end

  // busy from reset until init ends
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cmd_in_progress_o <= 1'b1;
    else if (accept)
      cmd_in_progress_o <= 1'b1;
    else if (done && to_idle)
      cmd_in_progress_o <= 1'b0;
  end

  // ********************************************************************
  // Host controller command
  // ********************************************************************
  // length from file count and size
  always_comb
  begin
    sh = `FSE_FILE_SHIFT + {2'b00, stored_file_size_o, 1'b0};
    start_sec = 64'(start_r) << sh;
    len_sec = 64'(n_r) << sh;
    su_cmd = FSE_HC_WRITE;
    su_addr = `FSE_META_LBA;
    su_len = 48'h0000_0000_0001;
    unique case (phase_r)
      FSE_PH_IDENT:
      begin
        su_cmd = FSE_HC_IDENT;
        su_len = 48'h0000_0000_0000;
      end
      FSE_PH_MREAD: su_cmd = FSE_HC_READ;
      FSE_PH_FMT: su_len = `FSE_FMT_SECTORS;
      FSE_PH_DATA:
      begin
        su_cmd = (cmd_r == FSE_CMD_READ) ? FSE_HC_READ : FSE_HC_WRITE;
        su_addr = `FSE_DATA_LBA + start_sec[47:0];
        su_len = len_sec[47:0];
      end
      FSE_PH_CAT: su_addr = `FSE_DIR_LBA + {39'h00_0000_0000, dir_idx};
      default: su_len = 48'h0000_0000_0001;
    endcase
  end

  // Request held until the controller shows busy
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hc_cmd_o <= 2'h0;
      hc_addr_o <= 48'h0000_0000_0000;
      hc_len_o <= 48'h0000_0000_0000;
      hc_req_o <= 1'b0;
    end
    else if (state_r == FSE_ST_LOAD)
    begin
      hc_cmd_o <= su_cmd;
      hc_addr_o <= su_addr;
      hc_len_o <= su_len;
      hc_req_o <= 1'b1;
    end
    else if (hc_busy_i)
      hc_req_o <= 1'b0;
  end

  // ********************************************************************
  // Data streaming
  // ********************************************************************
  assign src_fifo = (phase_r == FSE_PH_DATA) && (cmd_r == FSE_CMD_WRITE);
  assign src_gen = (phase_r == FSE_PH_FMT) || (phase_r == FSE_PH_META)
    || (phase_r == FSE_PH_CAT);
  assign src_rx = (phase_r == FSE_PH_MREAD)
    || ((phase_r == FSE_PH_DATA) && (cmd_r == FSE_CMD_READ));
  assign rd_go = run && src_fifo && !rem_zero && !tx_fifo_empty_i && !tx_fifo_read_en_o
    && !rd_pend_r && !hc_tx_valid_o;
  assign gen_go = run && src_gen && !rem_zero && !hc_tx_valid_o;
  assign rx_go = run && src_rx && !rem_zero && hc_rx_valid_i;
  assign step = rd_go || gen_go || rx_go;

  fse_counter #(
    .W(56),
    .UP(1'b0)
  ) u_rem (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .load_i(state_r == FSE_ST_LOAD),
    .load_val_i({1'b0, su_len, 7'h00}),
    .step_i(step),
    .count_o(rem_cnt),
    .zero_o(rem_zero)
  );

  // Word index inside the current host command
  fse_counter #(
    .W(17),
    .UP(1'b1)
  ) u_idx (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .load_i(state_r == FSE_ST_LOAD),
    .load_val_i(17'h0_0000),
    .step_i(step),
    .count_o(idx_cnt),
    .zero_o()
  );

  // One read in flight at a time; one word per four clocks but needs no skid buffer
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_fifo_read_en_o <= 1'b0;
      rd_pend_r <= 1'b0;
    end
    else
    begin
      tx_fifo_read_en_o <= rd_go;
      rd_pend_r <= tx_fifo_read_en_o;
    end
  end

  // word taken the clock after enable
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hc_tx_valid_o <= 1'b0;
      hc_tx_word_o <= 32'h0000_0000;
    end
    else if (rd_pend_r)
    begin
      hc_tx_valid_o <= 1'b1;
      hc_tx_word_o <= tx_fifo_read_word_i;
    end
    else if (gen_go)
    begin
      hc_tx_valid_o <= 1'b1;
      hc_tx_word_o <= gen_word;
    end
    else if (hc_tx_ready_i)
      hc_tx_valid_o <= 1'b0;
  end

  // pause the controller when room is short
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hc_rx_pause_o <= 1'b1;
    else
      hc_rx_pause_o <= &rx_fifo_fill_count_i[15:`FSE_RX_ROOM_LSB];
  end

  // writes follow controller words, which stop under pause
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_fifo_write_en_o <= 1'b0;
      rx_fifo_write_word_o <= 32'h0000_0000;
    end
    else
    begin
      rx_fifo_write_en_o <= rx_go && (phase_r == FSE_PH_DATA);
      rx_fifo_write_word_o <= hc_rx_word_i;
    end
  end

  // Stored layout words caught from the metadata sector
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_size_r <= 3'h0;
      meta_count_r <= 27'h000_0000;
    end
    else if (rx_go && phase_r == FSE_PH_MREAD)
    begin
      if (idx_cnt == 17'h0_0000)
        meta_size_r <= hc_rx_word_i[2:0];
      if (idx_cnt == 17'h0_0001)
        meta_count_r <= hc_rx_word_i[26:0];
    end
  end

  // ********************************************************************
  // Generated sectors: metadata, directories, catalogue
  // ********************************************************************
  // directory of the first file
  assign dir_idx = 9'(start_r / 27'(DIR_CAP));
  assign dir_k = 9'(idx_cnt[16:7] - 10'h001);
  always_comb
  begin
    gen_word = 32'h0000_0000;
    unique case (idx_cnt[6:0])
      7'h00:
        if (phase_r == FSE_PH_CAT)
          // first four of the seven hex digits of the number
          gen_word = {hex_ch({1'b0, start_r[26:24]}), hex_ch(start_r[23:20]),
            hex_ch(start_r[19:16]), hex_ch(start_r[15:12])};
        else if (phase_r == FSE_PH_FMT && idx_cnt[16:7] != 10'h000)
          gen_word = {8'h44, 8'h49, 8'h52, hex_ch({3'h0, dir_k[8]})};
        else
          gen_word = {29'h0000_0000, (phase_r == FSE_PH_FMT) ? sel_r : stored_file_size_o};
      7'h01:
        if (phase_r == FSE_PH_CAT)
          gen_word = {hex_ch(start_r[11:8]), hex_ch(start_r[7:4]), hex_ch(start_r[3:0]), 8'h2E};
        else if (phase_r == FSE_PH_FMT && idx_cnt[16:7] != 10'h000)
          gen_word = {hex_ch(dir_k[7:4]), hex_ch(dir_k[3:0]), 16'h0000};
        else
          gen_word = (phase_r == FSE_PH_META) ? {5'h00, count_nxt} : 32'h0000_0000;
      7'h02: gen_word = (phase_r == FSE_PH_CAT) ? {8'h42, 8'h49, 8'h4E, 8'h00} : date_r;
      7'h03: gen_word = (phase_r == FSE_PH_CAT) ? date_r : time_r;
      7'h04: gen_word = (phase_r == FSE_PH_CAT) ? time_r : 32'h0000_0000;
      7'h05: gen_word = (phase_r == FSE_PH_CAT) ? {5'h00, n_r} : 32'h0000_0000;
      default: gen_word = 32'h0000_0000;
    endcase
  end

  // ********************************************************************
  // Published figures
  // ********************************************************************
  // count never shrinks on write
  assign end_sum = {1'b0, start_r} + {1'b0, n_r};
  assign count_nxt = (end_sum > {1'b0, stored_file_count_o}) ? end_sum[26:0]
    : stored_file_count_o;
  assign cap_size = (phase_r == FSE_PH_FMT) ? sel_r : meta_size_r;
  assign cap_sh = `FSE_FILE_SHIFT + {2'b00, cap_size, 1'b0};
  assign cap_full = (lba_r - `FSE_DATA_LBA) >> cap_sh;
  assign cap_sat = (|cap_full[47:27]) ? 27'h7FF_FFFF : cap_full[26:0];

  // figures move only at phase ends
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      max_file_capacity_o <= 27'h000_0000;
      files_per_directory_o <= 20'h0_0000;
      stored_file_size_o <= 3'h0;
      stored_file_count_o <= 27'h000_0000;
    end
    else if (done)
    begin
      unique case (phase_r)
        FSE_PH_MREAD:
        begin
          files_per_directory_o <= 20'(DIR_CAP);
          max_file_capacity_o <= cap_sat;
          stored_file_size_o <= meta_size_r;
          stored_file_count_o <= meta_count_r;
        end
        FSE_PH_FMT:
        begin
          max_file_capacity_o <= cap_sat;
          stored_file_size_o <= sel_r;
          stored_file_count_o <= 27'h000_0000;
        end
        FSE_PH_CAT:
          stored_file_count_o <= count_nxt;
        default: stored_file_count_o <= stored_file_count_o;
      endcase
    end
  end

  // ********************************************************************
  // Drive size and errors
  // ********************************************************************
  // Drive size is read once when identify completes
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lba_r <= 48'h0000_0000_0000;
      cap_err_r <= 1'b0;
    end
    else if (done && phase_r == FSE_PH_IDENT)
    begin
      lba_r <= hc_lba_size_i;
      cap_err_r <= (hc_lba_size_i < `FSE_LBA_MIN) || (hc_lba_size_i >= `FSE_LBA_MAX);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      error_flag_o <= 1'b0;
    else if (hc_error_i || cap_err_r)
      error_flag_o <= 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      error_cause_o <= 32'h0000_0000;
    else
    begin
      error_cause_o[15:0] <= hc_error_type_i[15:0];
      error_cause_o[`FSE_ERR_CAP_BIT] <= cap_err_r;
    end
  end

  // ********************************************************************
  // Register slave
  // ********************************************************************
  fse_avmm_regs u_regs (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .status_i({21'h00_0000, stored_file_size_o, 1'b0, phase_r, state_r,
      error_flag_o, cmd_in_progress_o}),
    .fcount_i(stored_file_count_o),
    .fcap_i(max_file_capacity_o),
    .files_per_directory_i(files_per_directory_o),
    .errcause_i(error_cause_o),
    .accept_en_o(accept_en)
  );
endmodule : fse_engine

// >>> testbench/fse_engine_asserts.sv
// Port checker of the file-system command engine
`timescale 1ns/100ps
module fse_engine_asserts (
  input logic ref_clk_i, nrst_i, cmd_request_i, cmd_in_progress_o, error_flag_o,
  input logic [1:0] cmd_code_i,
  input logic [26:0] stored_file_count_o, max_file_capacity_o,
  input logic tx_fifo_empty_i, tx_fifo_read_en_o, rx_fifo_write_en_o,
  input logic [15:0] rx_fifo_fill_count_i,
  input logic [31:0] error_cause_o, hc_error_type_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_init_busy: assert property ($rose(nrst_i) |-> cmd_in_progress_o)
    else $error("busy low at reset release");
  a_busy_cause: assert property ($rose(cmd_in_progress_o) |-> $past(cmd_request_i)
    && $past(cmd_code_i) != 2'h1 && !$past(error_flag_o)) else $error("busy without request");
  a_figs_busy: assert property (cmd_in_progress_o && $past(cmd_in_progress_o)
    |-> $stable(stored_file_count_o)) else $error("count moved while busy");
  a_figs_idle: assert property (!cmd_in_progress_o && $past(cmd_in_progress_o) == 1'h0
    |-> $stable(stored_file_count_o) && $stable(max_file_capacity_o)) else $error("figures moved");
  a_rd_empty: assert property (tx_fifo_read_en_o |-> !$past(tx_fifo_empty_i))
    else $error("read of empty fifo");
  a_rx_stop: assert property ((&rx_fifo_fill_count_i[15:3]) [*8] |-> !rx_fifo_write_en_o)
    else $error("rx write while full");
  a_err_stick: assert property (error_flag_o |=> error_flag_o)
    else $error("error flag cleared");
  a_err_mirror: assert property (((error_cause_o ^ $past(hc_error_type_i)) & 32'h0000_FFFF)
    == 32'h0) else $error("cause not mirrored");
  // Main scenarios reached
  cover property ($rose(cmd_in_progress_o));
  cover property ($rose(error_flag_o));
  cover property (cmd_in_progress_o && cmd_code_i == 2'h3);
endmodule : fse_engine_asserts

// >>> testbench/fse_host_model.sv
// Behavioural storage host controller facing the engine
`timescale 1ns/100ps
module fse_host_model (
  input logic ref_clk_i, nrst_i, hc_req_o, hc_rx_pause_o, hc_tx_valid_o,
  input logic [1:0] hc_cmd_o,
  input logic [47:0] hc_len_o,
  output logic hc_busy_i, hc_rx_valid_i, hc_tx_ready_i,
  output logic [31:0] hc_rx_word_i
);
  logic [54:0] left_r;
  // Write words are taken at once while a command runs
  assign hc_tx_ready_i = hc_busy_i;
  // One command at a time; idle data lines toggle so no stale word is seen
  always_ff @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i)
      {hc_busy_i, hc_rx_valid_i, left_r, hc_rx_word_i} <= '0;
    else
    begin
      hc_rx_valid_i <= 1'h0;
      hc_rx_word_i <= ~hc_rx_word_i;
      if (hc_req_o && !hc_busy_i)
      begin
        hc_busy_i <= 1'h1;
        left_r <= (hc_cmd_o == 2'h0) ? '0 : {hc_len_o, 7'h00};
      end
      else if (left_r == '0)
        hc_busy_i <= 1'h0;
      else if (hc_cmd_o == 2'h2 && !hc_rx_pause_o)
      begin
        {hc_rx_valid_i, hc_rx_word_i} <= {1'h1, 32'h0};
        left_r <= left_r - 1;
      end
      else if (hc_cmd_o == 2'h3 && hc_tx_valid_o)
        left_r <= left_r - 1;
    end
endmodule : fse_host_model

// >>> testbench/tb.sv
// Testbench of the command engine with a host controller model
`timescale 1ns/100ps
module tb;
  logic ref_clk_i = 0, nrst_i = 0, cmd_request_i = 0, hc_error_i = 0, avs_read_i = 0;
  logic avs_write_i = 0, tx_fifo_empty_i = 0, cmd_in_progress_o, error_flag_o, tx_fifo_read_en_o;
  logic rx_fifo_write_en_o, hc_req_o, hc_busy_i, hc_tx_valid_o, hc_tx_ready_i, hc_rx_valid_i;
  logic hc_rx_pause_o, avs_waitrequest_o;
  logic [1:0] cmd_code_i = 0, hc_cmd_o;
  logic [2:0] file_size_sel_i = 0, stored_file_size_o;
  logic [26:0] start_file_number_i = 0, file_count_i = 0, max_file_capacity_o, stored_file_count_o;
  logic [31:0] creation_date_i = 0, creation_time_i = 0, tx_fifo_read_word_i = 32'h5A5A, q;
  logic [31:0] rx_fifo_write_word_o, error_cause_o, hc_error_type_i = 0, hc_tx_word_o;
  logic [31:0] hc_rx_word_i, avs_writedata_i = 0, avs_readdata_o;
  logic [47:0] hc_addr_o, hc_len_o, hc_lba_size_i = 48'h0000_0200_0000;
  logic [19:0] files_per_directory_o;
  logic [15:0] rx_fifo_fill_count_i = 0;
  logic [4:0] avs_address_i = 0;
  logic [3:0] avs_byteenable_i = 0;
  int num_errors = 0, n_compared = 0, cyc = 0;
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  fse_engine dut_u (.*);
  fse_host_model host_u (.*);
  // Cut a hang short
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Avalon access held until waitrequest is seen low
  task av(input logic w, input logic [4:0] a, input logic [31:0] d);
    {avs_address_i, avs_write_i, avs_read_i, avs_writedata_i} <= {a, w, !w, d};
    avs_byteenable_i <= 4'hF;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    {avs_read_i, avs_write_i} <= 2'h0;
    @(posedge ref_clk_i);
  endtask : av
  // Request until busy would show, then drop it and wait for idle
  task cmd(input logic [1:0] c, input logic [26:0] s, input logic b);
    {cmd_code_i, start_file_number_i, cmd_request_i} <= {c, s, 1'b1};
    {creation_date_i, creation_time_i} <= {32'h0000_0611, 32'h0000_1530};
    repeat (3) @(posedge ref_clk_i);
    chk(cmd_in_progress_o, b);
    cmd_request_i <= 1'b0;
    while (cmd_in_progress_o !== 1'b0) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
  endtask : cmd
  task t_init;
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    while (cmd_in_progress_o !== 1'b0) @(posedge ref_clk_i);
    chk(files_per_directory_o, 512);
    chk(stored_file_count_o, 0);
    $display("init test done");
  endtask : t_init
  task t_regs;
    av(0, 5'h00, 0); chk(q, 1);
    av(0, 5'h1C, 0); chk(q, 0);
    av(1, 5'h00, 0); cmd(2'h2, 27'h3, 0);
    av(1, 5'h00, 1); cmd(2'h1, 27'h3, 0);
    chk(stored_file_count_o, 0);
    $display("register test done");
  endtask : t_regs
  task t_wr_rd;
    cmd(2'h2, 27'h5, 1); chk(stored_file_count_o, 5);
    cmd(2'h2, 27'h2, 1); chk(stored_file_count_o, 5);
    cmd(2'h3, 27'h1, 1); chk(stored_file_count_o, 5);
    $display("write read test done");
  endtask : t_wr_rd
  task t_err;
    rx_fifo_fill_count_i <= 16'hFFFF;
    {hc_error_type_i, hc_error_i} <= {32'h0000_00A5, 1'b1};
    @(posedge ref_clk_i);
    hc_error_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    chk(error_flag_o, 1);
    chk(error_cause_o, 32'h0000_00A5);
    cmd(2'h3, 27'h0, 0);
    $display("error test done");
  endtask : t_err
  task t_cut(input logic [1:0] c, input logic [31:0] len, input logic [31:0] w);
    {cmd_code_i, start_file_number_i, file_count_i, cmd_request_i} <= {c, 27'h0, 27'h1, 1'b1};
    repeat (3) @(posedge ref_clk_i);
    cmd_request_i <= 1'b0;
    repeat (300) @(posedge ref_clk_i);
    chk(hc_len_o[31:0], len);
    chk(hc_tx_word_o, w);
    nrst_i <= 1'b0;
    t_init();
  endtask : t_cut
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial
  begin
    t_init();
    t_regs();
    t_wr_rd();
    t_cut(2'h0, 32'h0000_0201, 32'h0);
    t_cut(2'h2, 32'h0001_0000, 32'h5A5A);
    t_err();
    end_sim();
  end
endmodule : tb
bind fse_engine fse_engine_asserts chk_u (.*);
